//--- csw_defs.svh
// Summary of operation
// - Nine-bit multiplier field, factor is value plus two.
// - Six-bit signed fast RC tuning field.
// - Switch fuse one disables switching and monitoring.
// - Switching off: new source ignored, current follows fuse.
// - Switching off: switch request held at zero.
// - Equal current and new source aborts, clears request.
// - Valid switch clears PLL lock and fail flags.
// - Enable new source, await start-up and lock.
// - Count ten new clock cycles before changeover.
// - On completion clear request, copy new source.
// - Old source stops except kept low-power or secondary.
// - Processor keeps running during the switch.
// - Primary submode fixed by fuse, never switched.
// - Monitoring keeps low-power RC running except sleep.
// - Failure raises trap and falls back to fast RC.
// - Failed PLL source falls back to fast RC with PLL.
// - New source write only while configuration unlocked.
// - Source codes shared by current and new fields.
// - Monitor sets fail flag; software reads and clears.
// - Lock bit with permit fuse blocks configuration writes.
// - Lock status shows PLL locked, else zero.
`ifndef CSW_DEFS_SVH
`define CSW_DEFS_SVH
// Register byte offsets on the bus.
`define CSW_ADR_OSC_CTRL 8'h00
`define CSW_ADR_PLL_FBD 8'h04
`define CSW_ADR_FRC_TUNE 8'h08
`define CSW_ADR_UNLOCK 8'h0C
// Unlock keys written in order to the unlock register.
`define CSW_KEY_FIRST 8'h55
`define CSW_KEY_SECOND 8'hAA
// Reset values.
`define CSW_PLL_MULT_RST 9'h030
`define CSW_FRC_TUNE_RST 6'h00
// Control register field positions.
`define CSW_BIT_CUR_LSB 12
`define CSW_BIT_NEW_LSB 8
`define CSW_BIT_CFG_LOCK 7
`define CSW_BIT_PLL_LOCK 5
`define CSW_BIT_FAIL 3
`define CSW_BIT_SEC_EN 1
`define CSW_BIT_SW_REQ 0
// Timing counts.
`define CSW_NEW_CLK_CYCLES 10
`define CSW_FAIL_WINDOW 4
`endif

//--- csw_pkg.sv
package csw_pkg;
    // Clock source codes shared by the current and new source fields.
    typedef enum logic [2:0] {
        CSW_SRC_FRC = 3'h0,
        CSW_SRC_FRC_PLL = 3'h1,
        CSW_SRC_PRI = 3'h2,
        CSW_SRC_PRI_PLL = 3'h3,
        CSW_SRC_SEC = 3'h4,
        CSW_SRC_LOW_POWER_INTERNAL_RC = 3'h5,
        CSW_SRC_FRC_DIV16 = 3'h6,
        CSW_SRC_FRC_DIVN = 3'h7
    } csw_src_t;

    // Switch sequencer states, one-hot.
    typedef enum logic [4:0] {
        CSW_ST_IDLE = 5'h01,
        CSW_ST_CHECK = 5'h02,
        CSW_ST_WAIT = 5'h04,
        CSW_ST_COUNT = 5'h08,
        CSW_ST_DONE = 5'h10
    } csw_state_t;

    // Oscillator and PLL enables driven to the analog blocks.
    typedef struct packed {
        logic pll;
        logic low_power_internal_rc;
        logic sec;
        logic pri;
        logic fast_internal_rc;
    } csw_osc_en_t;
endpackage : csw_pkg

//--- csw_clock_switch.sv
// Local design decisions: the Wishbone register port and the address map.
`timescale 1ns/1ps
`include "csw_defs.svh"
module csw_clock_switch
    import csw_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic clock_switch_fuse_i,
    input wire logic lock_permit_fuse_i,
    input wire logic [2:0] initial_source_fuse_i,
    input wire logic [1:0] primary_submode_fuse_i,
    input wire logic watchdog_en_i,
    input wire logic sleep_i,
    input wire logic ost_done_i,
    input wire logic pll_locked_i,
    input wire logic new_clk_i,
    input wire logic sys_src_clk_i,
    input wire logic low_power_internal_rc_clk_i,
    output logic [2:0] sys_source_o,
    output logic [1:0] primary_submode_o,
    output csw_osc_en_t osc_en_o,
    output logic [8:0] pll_multiplier_field_o,
    output logic [5:0] tuning_field_o,
    output logic clock_fail_trap_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers.
    ////////////////////////////////////////////////////////////////////////////

    localparam int NSYNC = 14;
    logic [NSYNC-1:0] sync_in; // Raw pins and fuses.
    logic [NSYNC-1:0] sync1_q; // First stage, read only by the second.
    logic [NSYNC-1:0] sync2_q; // Second stage, safe to use.
    logic [2:0] clk_prev_q; // Third stage of the three clocks, for edge finding.

    assign sync_in = {clock_switch_fuse_i, lock_permit_fuse_i, initial_source_fuse_i, primary_submode_fuse_i,
                      watchdog_en_i, sleep_i, ost_done_i, pll_locked_i, new_clk_i, sys_src_clk_i, low_power_internal_rc_clk_i};

    // Two flip-flops on every pin, since all of them come from other domains.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync1_q <= '0;
            sync2_q <= '0;
            clk_prev_q <= '0;
        end else begin
            sync1_q <= sync_in;
            sync2_q <= sync1_q;
            clk_prev_q <= sync2_q[2:0];
        end
    end

    logic sw_fuse_s, permit_s, sleep_s, wdt_s, ost_s, pll_lk_s;
    logic [2:0] init_src_s;
    logic [1:0] submode_s;
    logic new_edge, sys_edge, low_power_internal_rc_edge;
    assign sw_fuse_s = sync2_q[13];
    assign permit_s = sync2_q[12];
    assign init_src_s = sync2_q[11:9];
    assign submode_s = sync2_q[8:7];
    assign wdt_s = sync2_q[6];
    assign sleep_s = sync2_q[5];
    assign ost_s = sync2_q[4];
    assign pll_lk_s = sync2_q[3];
    assign new_edge = sync2_q[2] & ~clk_prev_q[2];
    assign sys_edge = sync2_q[1] & ~clk_prev_q[1];
    assign low_power_internal_rc_edge = sync2_q[0] & ~clk_prev_q[0];
    // Note: bit 2 of the clock group is the new clock, bits [2:0] map to new, sys, low_power_internal_rc.

    ////////////////////////////////////////////////////////////////////////////
    // Decoding helpers.
    ////////////////////////////////////////////////////////////////////////////

    // Oscillators needed to run a given source code.
    function automatic csw_osc_en_t src_needs(input logic [2:0] code);
        csw_osc_en_t e;
        e = '0;
        e.fast_internal_rc = (code == CSW_SRC_FRC) || (code == CSW_SRC_FRC_PLL) || (code[2:1] == 2'b11);
        e.pri = (code[2:1] == 2'b01);
        e.sec = (code == CSW_SRC_SEC);
        e.low_power_internal_rc = (code == CSW_SRC_LOW_POWER_INTERNAL_RC);
        e.pll = (code == CSW_SRC_FRC_PLL) || (code == CSW_SRC_PRI_PLL);
        return e;
    endfunction : src_needs

    ////////////////////////////////////////////////////////////////////////////
    // Bus slave, unlock keys and control state.
    ////////////////////////////////////////////////////////////////////////////

    logic sw_en; // Switching and monitoring permitted.
    logic mon_en; // Monitor actively watching.
    logic fail; // One-cycle failure detect.
    logic ack_q, ack_d;
    logic [31:0] rdat_q, rdat_d;
    logic key1_q, key1_d; // First key seen.
    logic armed_q, armed_d; // Next write may touch the control register.
    logic [1:0] init_q, init_d; // Cycles after reset in which fuses are loaded.
    logic [2:0] cur_q, cur_d; // Current source field.
    logic [2:0] nsrc_q, nsrc_d; // New source field.
    logic cfg_lock_q, cfg_lock_d;
    logic pll_lock_q, pll_lock_d;
    logic cf_q, cf_d;
    logic sec_en_q, sec_en_d;
    logic req_q, req_d;
    logic [8:0] mult_q, mult_d;
    logic [5:0] tune_q, tune_d;
    logic [1:0] submode_q, submode_d;
    csw_state_t st_q, st_d;
    logic [3:0] ncnt_q, ncnt_d; // New clock cycle count.
    logic busy; // A switch is in flight.
    logic blocked; // Configuration writes refused.
    logic wr_hit, rd_hit;

    assign sw_en = ~sw_fuse_s;
    assign blocked = cfg_lock_q & permit_s;
    assign busy = (st_q != CSW_ST_IDLE);
    assign wr_hit = wb_cyc_i & wb_stb_i & ~ack_q & wb_we_i;
    assign rd_hit = wb_cyc_i & wb_stb_i & ~ack_q & ~wb_we_i;

    // Next values of registers, keys and the switch sequencer.
    always_comb begin
        logic [7:0] a;
        csw_osc_en_t need_new; // Oscillators the requested source relies on.
        csw_osc_en_t need_cur; // Oscillators the running source relies on.
        a = {wb_adr_i[7:2], 2'b00};
        need_new = src_needs(nsrc_q);
        need_cur = src_needs(cur_q);
        ack_d = wb_cyc_i & wb_stb_i & ~ack_q;
        rdat_d = rdat_q;
        key1_d = key1_q;
        armed_d = armed_q;
        init_d = init_q;
        cur_d = cur_q;
        nsrc_d = nsrc_q;
        cfg_lock_d = cfg_lock_q;
        pll_lock_d = osc_en_o.pll & pll_lk_s;
        cf_d = cf_q;
        sec_en_d = sec_en_q;
        req_d = req_q;
        mult_d = mult_q;
        tune_d = tune_q;
        submode_d = submode_q;
        st_d = st_q;
        ncnt_d = ncnt_q;
        // Fuses are loaded once they have crossed the synchroniser.
        if (init_q != 2'h3) begin
            init_d = init_q + 2'h1;
            cur_d = init_src_s;
            nsrc_d = init_src_s;
            submode_d = submode_s;
        end
        // Read path: unmapped addresses read as zero.
        if (rd_hit) begin
            unique case (a)
                `CSW_ADR_OSC_CTRL: rdat_d = {17'h00000, cur_q, 1'b0, nsrc_q, cfg_lock_q, 1'b0, pll_lock_q,
                                             1'b0, cf_q, 1'b0, sec_en_q, req_q};
                `CSW_ADR_PLL_FBD: rdat_d = {23'h000000, mult_q};
                `CSW_ADR_FRC_TUNE: rdat_d = {26'h0000000, tune_q};
                default: rdat_d = 32'h00000000;
            endcase
        end
        // Write path: every write uses up the unlock.
        if (wr_hit) begin
            armed_d = 1'b0;
            key1_d = 1'b0;
            if (a == `CSW_ADR_UNLOCK && wb_sel_i[0]) begin
                // two keys in order arm a single write.
                key1_d = (wb_dat_i[7:0] == `CSW_KEY_FIRST);
                armed_d = key1_q && (wb_dat_i[7:0] == `CSW_KEY_SECOND);
            end
            if (a == `CSW_ADR_OSC_CTRL && armed_q) begin
                if (wb_sel_i[1] && !blocked) begin
                    nsrc_d = wb_dat_i[10:8];
                end
                if (wb_sel_i[0]) begin
                    cfg_lock_d = wb_dat_i[`CSW_BIT_CFG_LOCK];
                    sec_en_d = wb_dat_i[`CSW_BIT_SEC_EN];
                    if (!wb_dat_i[`CSW_BIT_FAIL]) begin
                        cf_d = 1'b0;
                    end
                    if (wb_dat_i[`CSW_BIT_SW_REQ] && sw_en && !blocked) begin
                        req_d = 1'b1;
                    end
                end
            end
            if (a == `CSW_ADR_PLL_FBD && !blocked) begin
                if (wb_sel_i[1]) begin
                    mult_d[8] = wb_dat_i[8];
                end
                if (wb_sel_i[0]) begin
                    mult_d[7:0] = wb_dat_i[7:0];
                end
            end
            if (a == `CSW_ADR_FRC_TUNE && wb_sel_i[0]) begin
                tune_d = wb_dat_i[5:0];
            end
        end
        // Switch sequencer; the core is never stalled while it runs.
        unique case (st_q)
            CSW_ST_IDLE: begin
                if (req_q) begin
                    st_d = CSW_ST_CHECK;
                end
            end
            CSW_ST_CHECK: begin
                if (nsrc_q == cur_q) begin
                    req_d = 1'b0;
                    st_d = CSW_ST_IDLE;
                end else begin
                    pll_lock_d = 1'b0;
                    cf_d = 1'b0;
                    st_d = CSW_ST_WAIT;
                end
            end
            CSW_ST_WAIT: begin
                // crystal start-up and PLL lock gate readiness.
                if ((!need_new.pri || ost_s) && (!need_new.pll || pll_lk_s)) begin
                    ncnt_d = 4'h0;
                    st_d = CSW_ST_COUNT;
                end
            end
            CSW_ST_COUNT: begin
                if (new_edge) begin
                    ncnt_d = ncnt_q + 4'h1;
                    if (ncnt_q == 4'(`CSW_NEW_CLK_CYCLES - 1)) begin
                        st_d = CSW_ST_DONE;
                    end
                end
            end
            CSW_ST_DONE: begin
                cur_d = nsrc_q;
                req_d = 1'b0;
                st_d = CSW_ST_IDLE;
            end
            default: st_d = CSW_ST_IDLE;
        endcase
        // A detected failure overrides the request and the sequencer, and its flag wins over a clear.
        if (fail) begin
            cf_d = 1'b1;
            cur_d = need_cur.pll ? CSW_SRC_FRC_PLL : CSW_SRC_FRC;
            req_d = 1'b0;
            st_d = CSW_ST_IDLE;
        end
        if (!sw_en) begin
            req_d = 1'b0;
            cur_d = init_src_s;
            st_d = CSW_ST_IDLE;
        end
    end

    // Registers of the bus and sequencer group.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            rdat_q <= '0;
            key1_q <= 1'b0;
            armed_q <= 1'b0;
            init_q <= 2'h0;
            cur_q <= CSW_SRC_FRC;
            nsrc_q <= CSW_SRC_FRC;
            cfg_lock_q <= 1'b0;
            pll_lock_q <= 1'b0;
            cf_q <= 1'b0;
            sec_en_q <= 1'b0;
            req_q <= 1'b0;
            mult_q <= `CSW_PLL_MULT_RST;
            tune_q <= `CSW_FRC_TUNE_RST;
            submode_q <= 2'h0;
            st_q <= CSW_ST_IDLE;
            ncnt_q <= 4'h0;
        end else begin
            ack_q <= ack_d;
            rdat_q <= rdat_d;
            key1_q <= key1_d;
            armed_q <= armed_d;
            init_q <= init_d;
            cur_q <= cur_d;
            nsrc_q <= nsrc_d;
            cfg_lock_q <= cfg_lock_d;
            pll_lock_q <= pll_lock_d;
            cf_q <= cf_d;
            sec_en_q <= sec_en_d;
            req_q <= req_d;
            mult_q <= mult_d;
            tune_q <= tune_d;
            submode_q <= submode_d;
            st_q <= st_d;
            ncnt_q <= ncnt_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Fail-safe monitor.
    ////////////////////////////////////////////////////////////////////////////

    logic [2:0] win_q, win_d; // Low-power RC edges since the last source edge.
    logic trap_q, trap_d;

    // The monitor is idle in sleep because the source is stopped on purpose.
    assign mon_en = sw_en & ~sleep_s & (init_q == 2'h3);
    assign fail = mon_en & low_power_internal_rc_edge & ~sys_edge & (win_q == 3'(`CSW_FAIL_WINDOW - 1));

    // Window count restarts on every source edge.
    always_comb begin
        win_d = win_q;
        trap_d = fail;
        if (!mon_en || sys_edge || fail) begin
            win_d = 3'h0;
        end else if (low_power_internal_rc_edge) begin
            win_d = win_q + 3'h1;
        end
    end

    // Registers of the monitor group.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            win_q <= 3'h0;
            trap_q <= 1'b0;
        end else begin
            win_q <= win_d;
            trap_q <= trap_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs.
    ////////////////////////////////////////////////////////////////////////////

    // Old source drops as soon as the current field moves off it, unless sec_en_q, the watchdog or the monitor keeps it on.
    always_comb begin
        osc_en_o = src_needs(cur_q) | (busy ? src_needs(nsrc_q) : '0);
        osc_en_o.low_power_internal_rc = osc_en_o.low_power_internal_rc | wdt_s | mon_en;
        osc_en_o.sec = osc_en_o.sec | sec_en_q;
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;
    assign sys_source_o = cur_q;
    assign primary_submode_o = submode_q;
    assign pll_multiplier_field_o = mult_q;
    assign tuning_field_o = tune_q;
    assign clock_fail_trap_o = trap_q;

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    ////////////////////////////////////////////////////////////////////////////

    chk_req_held_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        sw_fuse_s |=> !req_q)
        else $error("switch request set while switching disabled");
    chk_redundant_abort: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_q == CSW_ST_CHECK && nsrc_q == cur_q && sw_en && !fail) |=> (!req_q && st_q == CSW_ST_IDLE))
        else $error("redundant switch not aborted");
    chk_start_clears: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_q == CSW_ST_CHECK && nsrc_q != cur_q && sw_en && !fail) |=> (!cf_q && !pll_lock_q))
        else $error("status not cleared at switch start");
    chk_ten_edges: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_q == CSW_ST_DONE) |-> (ncnt_q == 4'hA))
        else $error("changeover without ten new clock cycles");
    chk_done_copies: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_q == CSW_ST_DONE && sw_en && !fail) |=> (cur_q == $past(nsrc_q) && !req_q))
        else $error("completion did not copy source or clear request");
    chk_fail_fallback: assert property (@(posedge clk_i) disable iff (rst_i)
        (fail && sw_en) |=> (cf_q && clock_fail_trap_o && (cur_q == CSW_SRC_FRC || cur_q == CSW_SRC_FRC_PLL)))
        else $error("failure did not fall back");
    chk_lock_blocks: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_hit && blocked && wb_adr_i[7:2] == 6'h01) |=> $stable(mult_q))
        else $error("multiplier written while locked");
    chk_unlock_needed: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_hit && !armed_q && wb_adr_i[7:2] == 6'h00 && st_q == CSW_ST_IDLE && init_q == 2'h3) |=> $stable(nsrc_q))
        else $error("control written without unlock");
    chk_low_power_internal_rc_kept: assert property (@(posedge clk_i) disable iff (rst_i)
        mon_en |-> osc_en_o.low_power_internal_rc)
        else $error("low-power RC stopped while monitoring");
    chk_pll_status: assert property (@(posedge clk_i) disable iff (rst_i)
        pll_lock_q |-> $past(osc_en_o.pll))
        else $error("lock status set with PLL disabled");

endmodule : csw_clock_switch

//--- testbench.sv
`timescale 1ns/1ps
`include "csw_defs.svh"
//////////////////////////////////////////////////////////////////////
// Self-checking bench for the clock switch block, driven over Wishbone.
module testbench;
    import csw_pkg::*;
    logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, clock_fail_trap_o;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic clock_switch_fuse_i, lock_permit_fuse_i, watchdog_en_i, sleep_i, ost_done_i, pll_locked_i;
    logic new_clk_i, sys_src_clk_i, low_power_internal_rc_clk_i, run_src;
    logic [2:0] initial_source_fuse_i, sys_source_o, cur, src;
    logic [1:0] primary_submode_fuse_i, primary_submode_o;
    csw_osc_en_t osc_en_o;
    logic [8:0] pll_multiplier_field_o, mult;
    logic [5:0] tuning_field_o, tune;
    logic [3:0] div;
    int n_errors, checks_done, cyc_cnt, t0, n;

    csw_clock_switch dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .clock_switch_fuse_i(clock_switch_fuse_i),
        .lock_permit_fuse_i(lock_permit_fuse_i), .initial_source_fuse_i(initial_source_fuse_i),
        .primary_submode_fuse_i(primary_submode_fuse_i), .watchdog_en_i(watchdog_en_i),
        .sleep_i(sleep_i), .ost_done_i(ost_done_i), .pll_locked_i(pll_locked_i),
        .new_clk_i(new_clk_i), .sys_src_clk_i(sys_src_clk_i), .low_power_internal_rc_clk_i(low_power_internal_rc_clk_i),
        .sys_source_o(sys_source_o), .primary_submode_o(primary_submode_o), .osc_en_o(osc_en_o),
        .pll_multiplier_field_o(pll_multiplier_field_o), .tuning_field_o(tuning_field_o),
        .clock_fail_trap_o(clock_fail_trap_o));

    //////////////////////////////////////////////////////////////////////
    // The 50 ns system clock.
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    // Slow source clocks, kept far below the synchroniser limit so every edge is seen.
    always @(posedge clk_i) begin
        div <= div + 4'h1;
        cyc_cnt <= cyc_cnt + 1;
        new_clk_i <= div[1];
        sys_src_clk_i <= run_src ? div[1] : sys_src_clk_i;
        low_power_internal_rc_clk_i <= div[3];
    end

    //////////////////////////////////////////////////////////////////////
    // Compares one value and reports a mismatch at once.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask : chk

    // One classic Wishbone cycle; the request holds until ack is sampled high.
    task automatic bus(input logic we, input logic [7:0] adr, input logic [3:0] sel, input logic [31:0] dat);
        int k;
        k = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel;
        wb_dat_i <= dat;
        do begin
            @(posedge clk_i);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 20);
        rd = wb_dat_o;
        chk(32'(k < 20), 32'h1, "bus answer");
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask : bus

    // Control register write preceded by the two key unlock.
    task automatic ctl_wr(input logic [3:0] sel, input logic [31:0] dat);
        bus(1'b1, `CSW_ADR_UNLOCK, 4'h1, 32'(`CSW_KEY_FIRST));
        bus(1'b1, `CSW_ADR_UNLOCK, 4'h1, 32'(`CSW_KEY_SECOND));
        bus(1'b1, `CSW_ADR_OSC_CTRL, sel, dat);
    endtask : ctl_wr

    // Oscillators that should run once a switch has settled; monitoring keeps the low-power RC on.
    function automatic csw_osc_en_t exp_en(input logic [2:0] s);
        csw_osc_en_t e;
        e = '0;
        e.fast_internal_rc = (s == 3'h0 || s == 3'h1 || s >= 3'h6);
        e.pri = (s == 3'h2 || s == 3'h3);
        e.sec = (s == 3'h4);
        e.pll = (s == 3'h1 || s == 3'h3);
        e.low_power_internal_rc = 1'b1;
        return e;
    endfunction : exp_en

    // Ends the run with the verdict; used by the main sequence and the watchdog.
    task automatic stop_test();
        $display("mismatches %0d, comparisons %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : stop_test

    // Sized for all scenarios with wide slack; a hang ends here.
    initial begin
        repeat (20000) @(posedge clk_i);
        n_errors++;
        stop_test();
    end

    //////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(10967));
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
        {clock_switch_fuse_i, lock_permit_fuse_i, initial_source_fuse_i, sleep_i} = '0;
        {watchdog_en_i, ost_done_i, pll_locked_i, div, n_errors, checks_done, cyc_cnt} = '0;
        {new_clk_i, sys_src_clk_i, low_power_internal_rc_clk_i} = '0;
        ost_done_i = 1'b1;
        pll_locked_i = 1'b1;
        run_src = 1'b1;
        primary_submode_fuse_i = 2'($urandom);
        rst_i = 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (8) @(posedge clk_i);
        bus(1'b0, `CSW_ADR_PLL_FBD, 4'h3, 32'h0);
        chk(rd, 32'h30, "multiplier reset");
        bus(1'b0, `CSW_ADR_FRC_TUNE, 4'h3, 32'h0);
        chk(rd, 32'h0, "tuning reset");
        chk(32'(primary_submode_o), 32'(primary_submode_fuse_i), "submode");
        chk(32'(osc_en_o.low_power_internal_rc), 32'h1, "low-power rc kept on");
        // Field extremes first, then random values.
        for (int i = 0; i < 4; i++) begin
            mult = (i == 0) ? 9'h1FF : 9'($urandom);
            tune = (i == 0) ? 6'h1F : (i == 1) ? 6'h20 : 6'($urandom);
            bus(1'b1, `CSW_ADR_PLL_FBD, 4'h3, 32'(mult));
            bus(1'b1, `CSW_ADR_FRC_TUNE, 4'h1, 32'(tune));
            bus(1'b0, `CSW_ADR_PLL_FBD, 4'h3, 32'h0);
            chk(rd, 32'(mult), "multiplier read");
            chk(32'(pll_multiplier_field_o), 32'(mult), "multiplier out");
            chk(32'(tuning_field_o), 32'(tune), "tuning out");
        end
        bus(1'b0, 8'h10, 4'hF, 32'h0);
        chk(rd, 32'h0, "unmapped read");
        // A control write with no unlock must be dropped.
        bus(1'b1, `CSW_ADR_OSC_CTRL, 4'h2, 32'h200);
        bus(1'b0, `CSW_ADR_OSC_CTRL, 4'h3, 32'h0);
        chk(32'(rd[10:8]), 32'h0, "write without unlock");
        // Requesting the source already in use is abandoned.
        ctl_wr(4'h1, 32'h1);
        repeat (4) @(posedge clk_i);
        bus(1'b0, `CSW_ADR_OSC_CTRL, 4'h3, 32'h0);
        chk(32'(rd[0]), 32'h0, "redundant request cleared");
        chk(32'(sys_source_o), 32'h0, "redundant source");
        cur = 3'h0;
        for (int s = 0; s < 8; s++) begin
            // A failure mid-run sets the flag that the next valid switch must clear.
            if (s == 3) begin
                run_src <= 1'b0;
                n = 0;
                while (clock_fail_trap_o !== 1'b1 && n < 300) begin
                    @(posedge clk_i);
                    n++;
                end
                chk(32'(n < 300), 32'h1, "failure trap");
                run_src <= 1'b1;
                repeat (3) @(posedge clk_i);
                cur = (cur == 3'h1 || cur == 3'h3) ? 3'h1 : 3'h0;
                chk(32'(sys_source_o), 32'(cur), "fallback source");
                bus(1'b0, `CSW_ADR_OSC_CTRL, 4'h3, 32'h0);
                chk(32'(rd[3]), 32'h1, "fail flag set");
            end
            src = (s == 0) ? 3'h3 : 3'($urandom);
            if (src == cur) src = cur ^ 3'h1;
            if ((cur == 3'h1 && src == 3'h3) || (cur == 3'h3 && src == 3'h1)) src = 3'h0;
            ctl_wr(4'h2, 32'(src) << 8);
            // The fail bit is written as one, so only the switch start itself may clear the flag.
            ctl_wr(4'h1, 32'h9);
            t0 = cyc_cnt;
            n = 0;
            do begin
                bus(1'b0, `CSW_ADR_OSC_CTRL, 4'h3, 32'h0);
                n++;
            end while (rd[0] !== 1'b0 && n < 60);
            chk(32'(cyc_cnt - t0 >= 36), 32'h1, "ten new clock cycles");
            chk(32'(rd[14:12]), 32'(src), "current field");
            chk(32'(sys_source_o), 32'(src), "system source");
            chk(32'(rd[3]), 32'h0, "fail flag cleared");
            chk({27'h0000000, osc_en_o}, {27'h0000000, exp_en(src)}, "old source stopped");
            cur = src;
        end
        // With the lock bit and the permit fuse set, multiplier writes are refused.
        ctl_wr(4'h1, 32'h80);
        lock_permit_fuse_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        bus(1'b1, `CSW_ADR_PLL_FBD, 4'h3, 32'h5);
        chk(32'(pll_multiplier_field_o), 32'(mult), "locked write");
        lock_permit_fuse_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        bus(1'b1, `CSW_ADR_PLL_FBD, 4'h3, 32'h5);
        chk(32'(pll_multiplier_field_o), 32'h5, "unlocked write");
        // Switching disabled by fuse: request stays low and the fuse picks the source.
        clock_switch_fuse_i <= 1'b1;
        initial_source_fuse_i <= 3'h2;
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (8) @(posedge clk_i);
        ctl_wr(4'h2, 32'h400);
        ctl_wr(4'h1, 32'h1);
        bus(1'b0, `CSW_ADR_OSC_CTRL, 4'h3, 32'h0);
        chk(32'(rd[0]), 32'h0, "request held low");
        chk(32'(sys_source_o), 32'h2, "fuse source");
        stop_test();
    end
endmodule : testbench
